// >>> verilog/tle_thermal_event.sv
// Purpose: configuration, limit compare and event pin logic of a module temperature sensor
// Assumes: the serial front end hands over whole 16-bit word accesses on core_clk;
//          converter samples arrive as 13-bit two's complement on core_clk
// Notes: the event pin is open drain, shown as output level plus enable
//
// Notes on behaviour
// - config bits 15:11 read zero, writes to them are dropped
// - hysteresis field 10:9 selects off, 1.5, 3 or 6 degC on the upper and critical limits
// - a crossed upper or critical threshold ends only at or below threshold minus hysteresis
// - hysteresis field is frozen while either lock bit is set
// - power-down stops conversion, events and temperature updates; bus still works
// - power-down cannot be set while locked, but can always be cleared
// - critical lock bit freezes critical limit, sticky until power-on reset
// - window lock bit freezes upper and lower limits, sticky until reset
// - clear bit releases latched alert in interrupt mode, reads zero
// - status bit 4 reads one while the alert is asserted
// - enable bit gates the alert; frozen while either lock is set
// - critical-only bit limits alert to the critical limit; window lock freezes it
// - polarity bit chooses the asserted pin level
// - mode bit chooses comparator or interrupt behaviour
// - limits and temperature are two's complement
// - bits 12:2 are defined in every limit register, bit 2 is 0.25 degC
// - comparisons use bits 12:2 only; finer bits only show in temperature reads
// - alert asserts crossing above the upper limit and falling back to limit minus hysteresis
// - alert asserts crossing below the lower limit and rising back to it
// - critical alert holds until temperature is at or below limit minus hysteresis
// - temperature word bits 15:13 carry critical, upper and lower flags
`timescale 1ns/1ps
`default_nettype none
module tle_thermal_event (
   input wire logic core_clk,
   input wire logic resetn,
   input wire logic clkEn,
   input wire tle_pkg::tle_req_t regReq,
   output logic [15:0] regRdata,
   input wire logic sampleValid,
   input wire logic [12:0] sampleTemp,
   output logic convertEnable,
   output logic alertOut,
   output logic alertOe
);
   import tle_pkg::*;

   // ************************************************************
   // state
   // ************************************************************
   typedef struct packed {
      tle_cfg_t cfg;
      logic [10:0] upperLimit;
      logic [10:0] lowerLimit;
      logic [10:0] critLimit;
      logic [12:0] temp;
      tle_flags_t flags;
      logic latched;
      logic active;
      logic [15:0] rdata;
   } tle_state_t;

   tle_state_t st;
   tle_state_t next_st;

   function automatic logic [11:0] hystSteps(input logic [1:0] sel);
      unique case (sel)
         2'b00: hystSteps = HYST_OFF;
         2'b01: hystSteps = HYST_1P5;
         2'b10: hystSteps = HYST_3;
         2'b11: hystSteps = HYST_6;
      endcase
   endfunction : hystSteps

   // ************************************************************
   // compare, one extra bit so limit minus hysteresis cannot wrap
   // ************************************************************
   logic signed [11:0] tempQ;
   logic signed [11:0] upperQ;
   logic signed [11:0] lowerQ;
   logic signed [11:0] critQ;
   logic signed [11:0] hystQ;
   logic anyLock;
   tle_flags_t newFlags;
   tle_flags_t selOld;
   tle_flags_t selNew;
   logic wantCfg;
   logic clearReq;

   assign tempQ = {st.temp[12], st.temp[12:2]};
   assign upperQ = {st.upperLimit[10], st.upperLimit};
   assign lowerQ = {st.lowerLimit[10], st.lowerLimit};
   assign critQ = {st.critLimit[10], st.critLimit};
   assign hystQ = hystSteps(st.cfg.hyst);
   assign anyLock = st.cfg.critLock | st.cfg.winLock;
   assign wantCfg = regReq.write && regReq.ptr == PTR_CONFIG;
   assign clearReq = wantCfg && regReq.wdata[CFG_CLEAR];

   always_comb begin
      newFlags = st.flags;
      // crit and high: set above, release only at or below limit minus hysteresis
      if (tempQ > critQ) begin
         newFlags.crit = 1'b1;
      end else if (tempQ <= critQ - hystQ) begin
         newFlags.crit = 1'b0;
      end
      if (tempQ > upperQ) begin
         newFlags.high = 1'b1;
      end else if (tempQ <= upperQ - hystQ) begin
         newFlags.high = 1'b0;
      end
      newFlags.low = tempQ < lowerQ;
   end

   // critical-only hides the window flags from the alert
   assign selOld = {st.flags.crit, st.flags.high & ~st.cfg.critOnly,
      st.flags.low & ~st.cfg.critOnly};
   assign selNew = {newFlags.crit, newFlags.high & ~st.cfg.critOnly,
      newFlags.low & ~st.cfg.critOnly};

   // ************************************************************
   // next state
   // ************************************************************
   always_comb begin
      next_st = st;
      // frozen sampling and compare while powered down
      if (!st.cfg.powerDown) begin
         if (sampleValid) begin
            next_st.temp = sampleTemp;
         end
         next_st.flags = newFlags;
         if (st.cfg.intMode) begin
            // new condition wins over a clear in the same cycle
            next_st.latched = (st.latched & ~clearReq) | (selNew != selOld) | newFlags.crit;
         end else begin
            next_st.latched = 1'b0;
         end
      end else if (st.cfg.intMode && clearReq) begin
         next_st.latched = 1'b0;
      end
      if (regReq.write) begin
         unique case (regReq.ptr)
            PTR_CONFIG: begin
               if (!anyLock) begin
                  next_st.cfg.hyst = regReq.wdata[CFG_HYST_LO +: 2];
                  next_st.cfg.enable = regReq.wdata[CFG_ENABLE];
               end
               if (!regReq.wdata[CFG_PDOWN] || !anyLock) begin
                  next_st.cfg.powerDown = regReq.wdata[CFG_PDOWN];
               end
               next_st.cfg.critLock = st.cfg.critLock | regReq.wdata[CFG_CRIT_LOCK];
               next_st.cfg.winLock = st.cfg.winLock | regReq.wdata[CFG_WIN_LOCK];
               if (!st.cfg.winLock) begin
                  next_st.cfg.critOnly = regReq.wdata[CFG_CRIT_ONLY];
               end
               next_st.cfg.polarity = regReq.wdata[CFG_POL];
               next_st.cfg.intMode = regReq.wdata[CFG_MODE];
            end
            PTR_UPPER: begin
               if (!st.cfg.winLock) begin
                  next_st.upperLimit = regReq.wdata[12:2];
               end
            end
            PTR_LOWER: begin
               if (!st.cfg.winLock) begin
                  next_st.lowerLimit = regReq.wdata[12:2];
               end
            end
            PTR_CRIT: begin
               if (!st.cfg.critLock) begin
                  next_st.critLimit = regReq.wdata[12:2];
               end
            end
            default: begin
            end
         endcase
      end
      // comparator follows flags, interrupt follows latch
      if (st.cfg.powerDown) begin
         next_st.active = st.active & st.cfg.enable;
      end else if (st.cfg.intMode) begin
         next_st.active = st.cfg.enable & next_st.latched;
      end else begin
         next_st.active = st.cfg.enable & (|selNew);
      end
      if (regReq.read) begin
         unique case (regReq.ptr)
            PTR_CONFIG: next_st.rdata = {5'h00, st.cfg.hyst, st.cfg.powerDown,
               st.cfg.critLock, st.cfg.winLock, 1'b0, st.active, st.cfg.enable,
               st.cfg.critOnly, st.cfg.polarity, st.cfg.intMode};
            PTR_UPPER: next_st.rdata = {3'h0, st.upperLimit, 2'h0};
            PTR_LOWER: next_st.rdata = {3'h0, st.lowerLimit, 2'h0};
            PTR_CRIT: next_st.rdata = {3'h0, st.critLimit, 2'h0};
            PTR_TEMP: next_st.rdata = {st.flags.crit, st.flags.high, st.flags.low,
               st.temp};
            default: next_st.rdata = 16'h0000;
         endcase
      end
   end

   always_ff @(posedge core_clk) begin
      if (!resetn) begin
         // bits 5 and 4 of the reset word have no storage behind them
         st.cfg <= tle_cfg_t'({CONFIG_RESET[10:6], CONFIG_RESET[3:0]});
         st.upperLimit <= LIMIT_RESET;
         st.lowerLimit <= LIMIT_RESET;
         st.critLimit <= LIMIT_RESET;
         st.temp <= TEMP_RESET;
         st.flags <= '0;
         st.latched <= 1'b0;
         st.active <= 1'b0;
         st.rdata <= 16'h0000;
      end else if (clkEn) begin
         st <= next_st;
      end
   end

   // ************************************************************
   // outputs
   // ************************************************************
   assign regRdata = st.rdata;
   assign convertEnable = ~st.cfg.powerDown;
   assign alertOut = st.cfg.polarity;
   assign alertOe = st.active;

   // ************************************************************
   // checks
   // ************************************************************
   AST_CRIT_LOCK_STICKY: assert property (@(posedge core_clk) disable iff (!resetn)
      st.cfg.critLock |=> st.cfg.critLock)
      else $error("critical lock bit dropped");
   AST_WIN_LOCK_LIMIT: assert property (@(posedge core_clk) disable iff (!resetn)
      (clkEn && st.cfg.winLock && regReq.write && regReq.ptr == PTR_UPPER)
      |=> $stable(st.upperLimit))
      else $error("upper limit changed while window locked");
   AST_PDOWN_REFUSED: assert property (@(posedge core_clk) disable iff (!resetn)
      (clkEn && anyLock && !st.cfg.powerDown) |=> !st.cfg.powerDown)
      else $error("power-down set while locked");
   AST_HYST_FROZEN: assert property (@(posedge core_clk) disable iff (!resetn)
      anyLock |=> $stable(st.cfg.hyst))
      else $error("hysteresis changed while locked");
   AST_DISABLED_QUIET: assert property (@(posedge core_clk) disable iff (!resetn)
      (clkEn && !st.cfg.enable) |=> !alertOe)
      else $error("alert driven while disabled");
   AST_STS_READ: assert property (@(posedge core_clk) disable iff (!resetn)
      (clkEn && regReq.read && regReq.ptr == PTR_CONFIG)
      |=> regRdata[CFG_STS] == $past(alertOe) && regRdata[15:11] == 5'h00
          && !regRdata[CFG_CLEAR])
      else $error("config read shows wrong status or reserved bits");
   AST_PDOWN_FROZEN: assert property (@(posedge core_clk) disable iff (!resetn)
      st.cfg.powerDown |=> $stable(st.temp) && $stable(st.flags))
      else $error("temperature updated in power-down");
   AST_CRIT_HOLD: assert property (@(posedge core_clk) disable iff (!resetn)
      (clkEn && !st.cfg.powerDown && tempQ > critQ) |=> st.flags.crit)
      else $error("critical flag not set above limit");
   AST_COMPARATOR: assert property (@(posedge core_clk) disable iff (!resetn)
      (clkEn && !st.cfg.intMode && !st.cfg.powerDown && st.cfg.enable)
      |=> alertOe == (|$past(selNew)))
      else $error("comparator alert does not follow flags");
   AST_OPEN_DRAIN: assert property (@(posedge core_clk) disable iff (!resetn)
      alertOe |-> alertOut == st.cfg.polarity && $past(st.cfg.enable))
      else $error("alert driven at wrong level");
   AST_CLKEN_FREEZE: assert property (@(posedge core_clk) disable iff (!resetn)
      !clkEn |=> $stable(st))
      else $error("state moved while clock enable low");
   AST_LIMIT_UNUSED: assert property (@(posedge core_clk) disable iff (!resetn)
      (clkEn && regReq.read && (regReq.ptr == PTR_UPPER || regReq.ptr == PTR_LOWER
          || regReq.ptr == PTR_CRIT)) |=> regRdata[15:13] == 3'h0 && regRdata[1:0] == 2'h0)
      else $error("limit read shows unused bits");
   AST_TEMP_FLAGS: assert property (@(posedge core_clk) disable iff (!resetn)
      (clkEn && regReq.read && regReq.ptr == PTR_TEMP)
      |=> regRdata[TEMP_FLAG_CRIT] == $past(st.flags.crit)
          && regRdata[TEMP_FLAG_HIGH] == $past(st.flags.high)
          && regRdata[TEMP_FLAG_LOW] == $past(st.flags.low))
      else $error("temperature read shows wrong flags");
   AST_CRIT_LIMIT_LOCKED: assert property (@(posedge core_clk) disable iff (!resetn)
      (clkEn && st.cfg.critLock && regReq.write && regReq.ptr == PTR_CRIT)
      |=> $stable(st.critLimit))
      else $error("critical limit changed while locked");
   AST_LOWER_LOCKED: assert property (@(posedge core_clk) disable iff (!resetn)
      (clkEn && st.cfg.winLock && regReq.write && regReq.ptr == PTR_LOWER)
      |=> $stable(st.lowerLimit))
      else $error("lower limit changed while window locked");
   AST_ENABLE_FROZEN: assert property (@(posedge core_clk) disable iff (!resetn)
      anyLock |=> $stable(st.cfg.enable))
      else $error("enable bit changed while locked");
   AST_CRIT_ONLY_FROZEN: assert property (@(posedge core_clk) disable iff (!resetn)
      st.cfg.winLock |=> $stable(st.cfg.critOnly))
      else $error("critical-only bit changed while window locked");
   AST_CRIT_ONLY_MASK: assert property (@(posedge core_clk) disable iff (!resetn)
      (clkEn && st.cfg.critOnly && !st.cfg.intMode && !st.cfg.powerDown && !newFlags.crit)
      |=> !alertOe)
      else $error("window flag reached the alert in critical-only mode");
   AST_CLEAR_RELEASE: assert property (@(posedge core_clk) disable iff (!resetn)
      (clkEn && st.cfg.intMode && clearReq && !st.cfg.powerDown && selNew == selOld
          && !newFlags.crit) |=> !alertOe)
      else $error("clear did not release the latched alert");
   AST_HIGH_SET: assert property (@(posedge core_clk) disable iff (!resetn)
      (clkEn && !st.cfg.powerDown && tempQ > upperQ) |=> st.flags.high)
      else $error("upper flag not set above limit");
   AST_LOW_SET: assert property (@(posedge core_clk) disable iff (!resetn)
      (clkEn && !st.cfg.powerDown && tempQ < lowerQ) |=> st.flags.low)
      else $error("lower flag not set below limit");
   AST_HIGH_RELEASE: assert property (@(posedge core_clk) disable iff (!resetn)
      (clkEn && !st.cfg.powerDown && tempQ <= upperQ - hystQ) |=> !st.flags.high)
      else $error("upper flag kept below limit minus hysteresis");
endmodule : tle_thermal_event
`default_nettype wire

// >>> verilog/tle_pkg.sv
// Purpose: shared constants and carriers of the thermal limit event control block
// Assumes: 16-bit register words reached by pointer, temperature in 0.0625 degC steps
// Notes: limits keep bits 12:2 only; the rest of a limit word reads as zero
package tle_pkg;
   // register pointers
   localparam logic [7:0] PTR_CONFIG = 8'h01;
   localparam logic [7:0] PTR_UPPER = 8'h02;
   localparam logic [7:0] PTR_LOWER = 8'h03;
   localparam logic [7:0] PTR_CRIT = 8'h04;
   localparam logic [7:0] PTR_TEMP = 8'h05;
   // configuration field positions
   localparam int CFG_MODE = 0;
   localparam int CFG_POL = 1;
   localparam int CFG_CRIT_ONLY = 2;
   localparam int CFG_ENABLE = 3;
   localparam int CFG_STS = 4;
   localparam int CFG_CLEAR = 5;
   localparam int CFG_WIN_LOCK = 6;
   localparam int CFG_CRIT_LOCK = 7;
   localparam int CFG_PDOWN = 8;
   localparam int CFG_HYST_LO = 9;
   localparam int TEMP_FLAG_LOW = 13;
   localparam int TEMP_FLAG_HIGH = 14;
   localparam int TEMP_FLAG_CRIT = 15;
   // reset values
   localparam logic [15:0] CONFIG_RESET = 16'h0000;
   localparam logic [10:0] LIMIT_RESET = 11'h000;
   localparam logic [12:0] TEMP_RESET = 13'h0000;
   // hysteresis in quarter-degree steps: 1.5, 3 and 6 degC
   localparam logic [11:0] HYST_OFF = 12'h000;
   localparam logic [11:0] HYST_1P5 = 12'h006;
   localparam logic [11:0] HYST_3 = 12'h00c;
   localparam logic [11:0] HYST_6 = 12'h018;

   typedef struct packed {
      logic write;
      logic read;
      logic [7:0] ptr;
      logic [15:0] wdata;
   } tle_req_t;

   typedef struct packed {
      logic [1:0] hyst;
      logic powerDown;
      logic critLock;
      logic winLock;
      logic enable;
      logic critOnly;
      logic polarity;
      logic intMode;
   } tle_cfg_t;

   typedef struct packed {
      logic crit;
      logic high;
      logic low;
   } tle_flags_t;
endpackage : tle_pkg

// >>> testbench/tle_host_model.sv
// Purpose: host-side model issuing whole-word register accesses; resolves the event wire
// Assumes: one access per call, strobes held across exactly one taken edge
// Notes: the wire has a pull-up, so a released pin reads one
`timescale 1ns/1ps
`default_nettype none
module tle_host_model (
   input wire logic core_clk,
   input wire logic alertOut,
   input wire logic alertOe,
   input wire logic [15:0] regRdata,
   output var tle_pkg::tle_req_t regReq,
   output logic eventPin
);
   import tle_pkg::*;
   // pull-up on the motherboard side of the open-drain pin
   assign eventPin = alertOe ? alertOut : 1'b1;
   initial regReq = '0;
   task automatic writeReg(input logic [7:0] p, input logic [15:0] d);
      @(posedge core_clk);
      #1;
      regReq = '{write: 1'b1, read: 1'b0, ptr: p, wdata: d};
      @(posedge core_clk);
      #1;
      regReq = '0;
   endtask : writeReg
   task automatic readReg(input logic [7:0] p, output logic [15:0] d);
      @(posedge core_clk);
      #1;
      regReq = '{write: 1'b0, read: 1'b1, ptr: p, wdata: 16'h0000};
      @(posedge core_clk);
      #1;
      regReq = '0;
      @(posedge core_clk);
      #1;
      d = regRdata;
   endtask : readReg
endmodule : tle_host_model
`default_nettype wire

// >>> testbench/thermal_limit_event_control_tb.sv
// Purpose: self-checking bench for the thermal event control block
// Assumes: limits upper 25.0, lower -0.25, critical 64.0 degC once programmed
// Notes: lock bits are sticky, so the lock scenario runs last before a final reset
`timescale 1ns/1ps
`default_nettype none
module thermal_limit_event_control_tb;
   import tle_pkg::*;
   logic core_clk = 1'b0;
   logic resetn = 1'b0;
   logic clkEn = 1'b1;
   logic sampleValid = 1'b0;
   logic [12:0] sampleTemp = 13'h0000;
   tle_req_t regReq;
   logic [15:0] regRdata;
   logic convertEnable, alertOut, alertOe, eventPin;
   int bad_count = 0;
   int compares = 0;
   always #10 core_clk = ~core_clk;
   tle_thermal_event i_tle_thermal_event (.core_clk(core_clk), .resetn(resetn), .clkEn(clkEn),
      .regReq(regReq), .regRdata(regRdata), .sampleValid(sampleValid),
      .sampleTemp(sampleTemp), .convertEnable(convertEnable), .alertOut(alertOut),
      .alertOe(alertOe));
   tle_host_model i_tle_host_model (.core_clk(core_clk), .alertOut(alertOut),
      .alertOe(alertOe), .regRdata(regRdata), .regReq(regReq), .eventPin(eventPin));
   task automatic chk16(input string what, input logic [15:0] e, input logic [15:0] g);
      compares++;
      if (g !== e) begin
         bad_count++;
         $display("CHECK FAILED %s expected %h seen %h", what, e, g);
      end
   endtask : chk16
   task automatic chkBit(input string what, input logic e, input logic g);
      compares++;
      if (g !== e) begin
         bad_count++;
         $display("CHECK FAILED %s expected %b seen %b", what, e, g);
      end
   endtask : chkBit
   task automatic wr(input logic [7:0] p, input logic [15:0] d);
      i_tle_host_model.writeReg(p, d);
   endtask : wr
   task automatic rd(input string what, input logic [7:0] p, input logic [15:0] e);
      logic [15:0] d;
      i_tle_host_model.readReg(p, d);
      chk16(what, e, d);
   endtask : rd
   // the pin reads the polarity level when asserted, the pull-up level when released
   task automatic pin(input logic act, input logic pol);
      chkBit("alertOe", act, alertOe);
      chkBit("eventPin", act ? pol : 1'b1, eventPin);
   endtask : pin
   task automatic smp(input logic [12:0] t);
      @(posedge core_clk);
      #1;
      sampleTemp = t;
      sampleValid = 1'b1;
      @(posedge core_clk);
      #1;
      sampleValid = 1'b0;
      repeat (3) @(posedge core_clk);
      #1;
   endtask : smp
   task automatic doReset();
      @(posedge core_clk);
      #1;
      resetn = 1'b0;
      repeat (16) @(posedge core_clk);
      #1;
      resetn = 1'b1;
   endtask : doReset
   task automatic scnReset();
      rd("config", PTR_CONFIG, 16'h0000);
      rd("upper", PTR_UPPER, 16'h0000);
      rd("unmapped", 8'h09, 16'h0000);
      chkBit("convertEnable", 1'b1, convertEnable);
      pin(1'b0, 1'b0);
      // a write while the clock enable is low must not land
      @(posedge core_clk);
      #1;
      clkEn = 1'b0;
      wr(PTR_CONFIG, 16'h0008);
      clkEn = 1'b1;
      rd("config frozen", PTR_CONFIG, 16'h0000);
   endtask : scnReset
   task automatic scnFields();
      wr(PTR_CONFIG, 16'hf82b);
      rd("config", PTR_CONFIG, 16'h000b);
      wr(PTR_CONFIG, 16'h0000);
      wr(PTR_CRIT, 16'h0400);
      wr(PTR_UPPER, 16'he193);
      rd("upper", PTR_UPPER, 16'h0190);
      wr(PTR_LOWER, 16'h1ffc);
      rd("lower", PTR_LOWER, 16'h1ffc);
   endtask : scnFields
   task automatic scnComparator();
      wr(PTR_CONFIG, 16'h0008);
      smp(13'h0193);
      pin(1'b0, 1'b0);
      rd("temp", PTR_TEMP, 16'h0193);
      smp(13'h0194);
      pin(1'b1, 1'b0);
      rd("config", PTR_CONFIG, 16'h0018);
      rd("temp", PTR_TEMP, 16'h4194);
      smp(13'h0190);
      pin(1'b0, 1'b0);
      wr(PTR_CONFIG, 16'h0208);
      smp(13'h0194);
      smp(13'h017c);
      pin(1'b1, 1'b0);
      smp(13'h0178);
      pin(1'b0, 1'b0);
      wr(PTR_CONFIG, 16'h0408);
      smp(13'h0194);
      smp(13'h0164);
      pin(1'b1, 1'b0);
      wr(PTR_CONFIG, 16'h0608);
      smp(13'h0134);
      pin(1'b1, 1'b0);
      smp(13'h0130);
      pin(1'b0, 1'b0);
      wr(PTR_CONFIG, 16'h0008);
      smp(13'h1fd4);
      pin(1'b1, 1'b0);
      rd("temp", PTR_TEMP, 16'h3fd4);
      smp(13'h1ffc);
      pin(1'b0, 1'b0);
      wr(PTR_CONFIG, 16'h000c);
      smp(13'h0194);
      pin(1'b0, 1'b0);
      smp(13'h0404);
      pin(1'b1, 1'b0);
      rd("temp", PTR_TEMP, 16'hc404);
      smp(13'h0100);
      wr(PTR_CONFIG, 16'h0000);
      smp(13'h0194);
      pin(1'b0, 1'b0);
      smp(13'h0100);
   endtask : scnComparator
   task automatic scnInterrupt();
      wr(PTR_CONFIG, 16'h000b);
      smp(13'h0194);
      pin(1'b1, 1'b1);
      smp(13'h0100);
      pin(1'b1, 1'b1);
      wr(PTR_CONFIG, 16'h002b);
      repeat (2) @(posedge core_clk);
      #1;
      pin(1'b0, 1'b1);
      wr(PTR_CONFIG, 16'h0008);
      smp(13'h0194);
      wr(PTR_CONFIG, 16'h0028);
      repeat (2) @(posedge core_clk);
      #1;
      pin(1'b1, 1'b0);
      smp(13'h0100);
   endtask : scnInterrupt
   task automatic scnLocks();
      wr(PTR_CONFIG, 16'h0108);
      @(posedge core_clk);
      #1;
      chkBit("convertEnable", 1'b0, convertEnable);
      smp(13'h0194);
      pin(1'b0, 1'b0);
      rd("temp", PTR_TEMP, 16'h0100);
      wr(PTR_CONFIG, 16'h0148);
      wr(PTR_CONFIG, 16'h0040);
      rd("config", PTR_CONFIG, 16'h0048);
      wr(PTR_CONFIG, 16'h0707);
      rd("config", PTR_CONFIG, 16'h004b);
      wr(PTR_UPPER, 16'h0200);
      rd("upper", PTR_UPPER, 16'h0190);
      wr(PTR_CONFIG, 16'h00cb);
      wr(PTR_CRIT, 16'h0800);
      rd("crit", PTR_CRIT, 16'h0400);
      wr(PTR_CONFIG, 16'h0003);
      rd("config", PTR_CONFIG, 16'h00cb);
      doReset();
      rd("config", PTR_CONFIG, 16'h0000);
   endtask : scnLocks
   task automatic results();
      $display("mismatches %0d of %0d compares", bad_count, compares);
      if (bad_count == 0 && compares > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask : results
   initial begin
      #200000;
      bad_count++;
      results();
   end
   initial begin
      doReset();
      scnReset();
      scnFields();
      scnComparator();
      scnInterrupt();
      scnLocks();
      results();
   end
endmodule : thermal_limit_event_control_tb
`default_nettype wire
